// file: include/scs_pkg.sv
// Shared constants and types for the service channel scheduler.
// Assumes one clock domain and a communication-cycle tick from outside.
`default_nettype none
package scs_pkg;

  localparam int SVC_W           = 16;
  localparam int CTL_QUEUE_DEPTH = 16;
  localparam int RSP_FIFO_DEPTH  = 8;
  localparam int CYC_SLOTS       = 8;

  // Phase numbering of the ring start-up
  localparam logic [2:0] PHASE_FIRST   = 3'h0;
  localparam logic [2:0] PHASE_LAST    = 3'h4;
  // Phase 3 is entered only once phase 2 is complete
  localparam logic [2:0] PHASE_SVC_MIN = 3'h3;

  // Telegram: one reserved service word plus one word per cyclic slot
  localparam logic [3:0] SVC_WORDS = 4'h1;

  // Service header word layout
  localparam int HDR_WR_BIT    = 15;
  localparam int HDR_ELEM_LSB  = 12;
  localparam int HDR_SLAVE_LSB = 0;

  localparam logic [15:0] SVC_IDLE_WORD = 16'h0000;

  typedef enum logic [2:0] {
    ELEM_NAME   = 3'h1,
    ELEM_ATTR   = 3'h2,
    ELEM_UNITS  = 3'h3,
    ELEM_MIN    = 3'h4,
    ELEM_MAX    = 3'h5,
    ELEM_OPDATA = 3'h7
  } scs_elem_t;

  typedef enum logic [1:0] {
    SVC_IDLE = 2'b00,
    SVC_HDR  = 2'b01,
    SVC_IDN  = 2'b10,
    SVC_DATA = 2'b11
  } scs_svc_state_t;

  typedef struct packed {
    logic        wr;
    scs_elem_t   elem;
    logic [7:0]  slave;
    logic [15:0] idn;
    logic [7:0]  len;
  } scs_req_t;

  typedef struct packed {
    logic        src;
    logic        last;
    logic [15:0] word;
  } scs_rsp_t;

endpackage
`default_nettype wire

// file: hdl/scs_fifo.sv
// Flip-flop FIFO with valid/ready on both sides.
// Assumes a single clock; full and empty are exact counts.
`timescale 1ns/100ps
`default_nettype none
module scs_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 8
) (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic             inValid,
  output logic                  inReady,
  input  wire logic [WIDTH-1:0] inData,
  output logic                  outValid,
  input  wire logic             outReady,
  output logic      [WIDTH-1:0] outData
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [AW:0] FULL_CNT = (AW + 1)'(DEPTH);
  localparam logic [AW-1:0] LAST_IDX = AW'(DEPTH - 1);

  logic [WIDTH-1:0] memQ [DEPTH];
  logic [AW-1:0]    wrPtrQ;
  logic [AW-1:0]    rdPtrQ;
  logic [AW:0]      countQ;
  wire              push = inValid && inReady;
  wire              pop  = outValid && outReady;

  assign inReady  = (countQ != FULL_CNT);
  assign outValid = (countQ != '0);
  assign outData  = memQ[rdPtrQ];

  always_ff @(posedge clk) begin
    if (push) begin
      memQ[wrPtrQ] <= inData;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wrPtrQ <= '0;
      rdPtrQ <= '0;
      countQ <= '0;
    end else begin
      if (push) begin
        wrPtrQ <= (wrPtrQ == LAST_IDX) ? '0 : wrPtrQ + 1'b1;
      end
      if (pop) begin
        rdPtrQ <= (rdPtrQ == LAST_IDX) ? '0 : rdPtrQ + 1'b1;
      end
      if (push && !pop) begin
        countQ <= countQ + 1'b1;
      end else if (pop && !push) begin
        countQ <= countQ - 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// file: hdl/scs_phase_seq.sv
// Ring start-up phase sequencer, steps one phase per granted request.
// Assumes advance requests are single-cycle pulses from the start-up control.
`timescale 1ns/100ps
`default_nettype none
module scs_phase_seq (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       cycleTick,
  input  wire logic       advReq,
  output logic      [2:0] phase,
  output logic            lastDone
);
  logic [2:0] phaseQ;
  logic       pendQ;
  logic       lastDoneQ;
  wire        step = cycleTick && (pendQ || advReq);

  assign phase    = phaseQ;
  assign lastDone = lastDoneQ;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      phaseQ    <= scs_pkg::PHASE_FIRST;
      pendQ     <= 1'b0;
      lastDoneQ <= 1'b0;
    end else begin
      // A request between ticks is held for the next tick; several merge into one step
      pendQ <= (pendQ || advReq) && !cycleTick;
      if (step && phaseQ != scs_pkg::PHASE_LAST) begin
        phaseQ <= phaseQ + 3'h1; // R16
      end else if (step) begin
        lastDoneQ <= 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// file: hdl/scs_scheduler.sv
// Service channel scheduler and cyclic word gate of a ring master.
// Assumes cycleTick pulses once per communication cycle and all inputs
// are synchronous to clk.
//
// Summary of operation
// R1: One service word is always in the telegram, pending request or not.
// R2: Service word goes out in master telegram, answer read from drive.
// R3: Exactly one service word per update; long transfers span updates.
// R4: Only one service request runs at a time, next waits for completion.
// R5: Control program queue holds up to 16 pending requests.
// R6: Queued requests run and complete in queued order.
// R7: All queued control requests are served before any diagnostic one.
// R8: Service transfers only after phase 2 is complete.
// R9: Cyclic words are sent only after phase 4 is complete.
// R10: Once running, every configured cyclic word is sent each cycle.
// R11: Cyclic configuration locks after phase 4; later changes refused.
// R12: Each cyclic item has its own telegram word, lengthening it.
// R13: Only the operation-data element may be mapped to a cyclic slot.
// R14: Service channel reaches every element of an identification number.
// R15: Master always starts service transfers; drive only answers.
// R16: Phases 0 to 4 advance strictly in sequence.
// R17: Full control queue rejects the request and flags queue full.
`timescale 1ns/100ps
`default_nettype none
module scs_scheduler (
  input  wire logic              clk,
  input  wire logic              rst,
  input  wire logic              cycleTick,
  input  wire logic              phaseAdvReq,
  output logic             [2:0] ringPhase,
  output logic                   cyclicRun,
  input  wire logic              ctlReqValid,
  output logic                   ctlReqReady,
  input  wire scs_pkg::scs_req_t ctlReq,
  output logic                   ctlQueueFull,
  output logic                   ctlReqRejected,
  input  wire logic              diagReqValid,
  output logic                   diagReqReady,
  input  wire scs_pkg::scs_req_t diagReq,
  input  wire logic              wrDataValid,
  output logic                   wrDataReady,
  input  wire logic       [15:0] wrData,
  output logic                   rspValid,
  input  wire logic              rspReady,
  output scs_pkg::scs_rsp_t      rsp,
  output logic                   svcBusy,
  output logic                   svcDone,
  output logic                   svcDoneSrc,
  output logic            [15:0] mdtSvcWord,
  input  wire logic       [15:0] atSvcWord,
  output logic             [3:0] telLength,
  input  wire logic              cfgWrEn,
  input  wire logic        [2:0] cfgSlot,
  input  wire logic       [15:0] cfgIdn,
  input  wire scs_pkg::scs_elem_t cfgElem,
  output logic                   cfgRefused,
  output logic             [3:0] cycCount,
  output logic                   cycSlotValid,
  output logic             [2:0] cycSlotIdx,
  output logic            [15:0] cycSlotIdn
);
  localparam int RSP_W = $bits(scs_pkg::scs_rsp_t);
  localparam int REQ_W = $bits(scs_pkg::scs_req_t);
  localparam logic SRC_CTL  = 1'b0;
  localparam logic SRC_DIAG = 1'b1;

  // Phase sequencing
  logic [2:0] phase;
  logic       lastDone;

  scs_phase_seq uPhase (
    .clk      (clk),
    .rst      (rst),
    .cycleTick(cycleTick),
    .advReq   (phaseAdvReq),
    .phase    (phase),
    .lastDone (lastDone)
  );

  wire svcAllowed = (phase >= scs_pkg::PHASE_SVC_MIN); // R8
  assign ringPhase = phase;
  assign cyclicRun = lastDone; // R9

  // Control-program request queue
  scs_pkg::scs_req_t ctlHead;
  logic              ctlHeadValid;
  logic              ctlPop;

  scs_fifo #(
    .WIDTH(REQ_W),
    .DEPTH(scs_pkg::CTL_QUEUE_DEPTH)
  ) uCtlQueue ( // R5 R6
    .clk     (clk),
    .rst     (rst),
    .inValid (ctlReqValid),
    .inReady (ctlReqReady),
    .inData  (ctlReq),
    .outValid(ctlHeadValid),
    .outReady(ctlPop),
    .outData (ctlHead)
  );

  assign ctlQueueFull = !ctlReqReady; // R17

  logic rejectQ;
  assign ctlReqRejected = rejectQ;

  // Service transfer state
  scs_pkg::scs_svc_state_t stateQ;
  scs_pkg::scs_req_t       curQ;
  logic                    srcQ;
  logic [7:0]              remainQ;
  logic [15:0]             mdtWordQ;
  logic                    doneQ;
  logic                    doneSrcQ;

  wire idle      = (stateQ == scs_pkg::SVC_IDLE);
  wire grantOk   = idle && svcAllowed; // R4 R8
  wire grantCtl  = grantOk && ctlHeadValid; // R7
  wire grantDiag = grantOk && !ctlHeadValid && diagReqValid; // R7
  assign ctlPop       = grantCtl;
  assign diagReqReady = grantOk && !ctlHeadValid;

  // Response buffer, drained by the consumer; a full buffer stalls reads
  logic              rspInValid;
  logic              rspInReady;
  scs_pkg::scs_rsp_t rspIn;

  scs_fifo #(
    .WIDTH(RSP_W),
    .DEPTH(scs_pkg::RSP_FIFO_DEPTH)
  ) uRspFifo (
    .clk     (clk),
    .rst     (rst),
    .inValid (rspInValid),
    .inReady (rspInReady),
    .inData  (rspIn),
    .outValid(rspValid),
    .outReady(rspReady),
    .outData (rsp)
  );

  wire inData    = (stateQ == scs_pkg::SVC_DATA);
  wire dataTick  = cycleTick && inData;
  wire wrStep    = dataTick && curQ.wr && wrDataValid;
  wire rdStep    = dataTick && !curQ.wr && rspInReady;
  wire dataStep  = wrStep || rdStep; // R3
  wire lastWord  = (remainQ == 8'h01);
  wire noData    = (curQ.len == 8'h00);

  assign wrDataReady = dataTick && curQ.wr;
  // Drive answer is taken only while a master-started read runs
  assign rspInValid  = rdStep; // R15 R2
  assign rspIn       = '{src: srcQ, last: lastWord, word: atSvcWord};

  // Header carries the element selector, so any element can be reached
  wire [15:0] hdrWord = (16'(curQ.wr) << scs_pkg::HDR_WR_BIT)
                      | (16'(curQ.elem) << scs_pkg::HDR_ELEM_LSB)
                      | (16'(curQ.slave) << scs_pkg::HDR_SLAVE_LSB); // R14

  logic [15:0] mdtNext;
  always_comb begin
    mdtNext = scs_pkg::SVC_IDLE_WORD;
    unique case (stateQ)
      scs_pkg::SVC_IDLE: mdtNext = scs_pkg::SVC_IDLE_WORD;
      scs_pkg::SVC_HDR:  mdtNext = hdrWord;
      scs_pkg::SVC_IDN:  mdtNext = curQ.idn;
      scs_pkg::SVC_DATA: mdtNext = wrStep ? wrData : mdtWordQ;
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      stateQ   <= scs_pkg::SVC_IDLE;
      curQ     <= '0;
      srcQ     <= SRC_CTL;
      remainQ  <= 8'h00;
      mdtWordQ <= scs_pkg::SVC_IDLE_WORD;
      doneQ    <= 1'b0;
      doneSrcQ <= SRC_CTL;
      rejectQ  <= 1'b0;
    end else begin
      doneQ   <= 1'b0;
      rejectQ <= ctlReqValid && !ctlReqReady; // R17
      // Word is refreshed every tick, idle or not
      if (cycleTick) begin
        mdtWordQ <= mdtNext; // R1 R2
      end
      unique case (stateQ)
        scs_pkg::SVC_IDLE: begin
          if (grantCtl) begin
            curQ   <= ctlHead;
            srcQ   <= SRC_CTL;
            stateQ <= scs_pkg::SVC_HDR;
          end else if (grantDiag) begin
            curQ   <= diagReq;
            srcQ   <= SRC_DIAG;
            stateQ <= scs_pkg::SVC_HDR;
          end
        end
        scs_pkg::SVC_HDR: begin
          if (cycleTick) begin
            stateQ <= scs_pkg::SVC_IDN; // R15
          end
        end
        scs_pkg::SVC_IDN: begin
          if (cycleTick) begin
            remainQ <= curQ.len;
            if (noData) begin
              stateQ   <= scs_pkg::SVC_IDLE;
              doneQ    <= 1'b1;
              doneSrcQ <= srcQ;
            end else begin
              stateQ <= scs_pkg::SVC_DATA;
            end
          end
        end
        scs_pkg::SVC_DATA: begin
          if (dataStep) begin
            remainQ <= remainQ - 8'h01; // R3
            if (lastWord) begin
              stateQ   <= scs_pkg::SVC_IDLE; // R4
              doneQ    <= 1'b1;
              doneSrcQ <= srcQ;
            end
          end
        end
      endcase
    end
  end

  assign svcBusy    = !idle;
  assign svcDone    = doneQ;
  assign svcDoneSrc = doneSrcQ;
  assign mdtSvcWord = mdtWordQ;

  // Cyclic slot configuration
  logic [15:0] slotIdnQ [scs_pkg::CYC_SLOTS];
  logic [3:0]  cycCountQ;
  logic        refuseQ;

  wire cfgLocked = lastDone; // R11
  wire cfgBadEl  = (cfgElem != scs_pkg::ELEM_OPDATA); // R13
  wire cfgTake   = cfgWrEn && !cfgLocked && !cfgBadEl;
  wire [3:0] cfgSlotEnd = 4'(cfgSlot) + 4'h1;

  genvar s;
  generate
    for (s = 0; s < scs_pkg::CYC_SLOTS; s++) begin : gSlot
      always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
          slotIdnQ[s] <= 16'h0000;
        end else if (cfgTake && cfgSlot == 3'(s)) begin
          slotIdnQ[s] <= cfgIdn; // R12
        end
      end
    end
  endgenerate

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cycCountQ <= 4'h0;
      refuseQ   <= 1'b0;
    end else begin
      refuseQ <= cfgWrEn && !cfgTake; // R11 R13
      if (cfgTake && cfgSlotEnd > cycCountQ) begin
        cycCountQ <= cfgSlotEnd; // R12
      end
    end
  end

  assign cfgRefused = refuseQ;
  assign cycCount   = cycCountQ;
  // The telegram holds one word per slot up to the highest mapped one
  assign telLength  = scs_pkg::SVC_WORDS + cycCountQ; // R1 R12

  // Cyclic word emission: one slot per clock after each tick.
  // Slots must fit between ticks; 8 slots take 8 clocks, so ticks must be at least 8 clocks apart.
  logic       emitQ;
  logic [2:0] emitIdxQ;
  logic [15:0] emitIdnQ;
  wire [3:0]  emitIdxNext = 4'(emitIdxQ) + 4'h1;
  wire        emitStart   = cycleTick && lastDone && cycCountQ != 4'h0;
  wire        emitMore    = emitQ && emitIdxNext < cycCountQ;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      emitQ    <= 1'b0;
      emitIdxQ <= 3'h0;
      emitIdnQ <= 16'h0000;
    end else begin
      if (emitStart) begin
        emitQ    <= 1'b1; // R9 R10
        emitIdxQ <= 3'h0;
        emitIdnQ <= slotIdnQ[0];
      end else if (emitMore) begin
        emitIdxQ <= emitIdxNext[2:0]; // R10
        emitIdnQ <= slotIdnQ[emitIdxNext[2:0]];
      end else begin
        emitQ <= 1'b0;
      end
    end
  end

  assign cycSlotValid = emitQ;
  assign cycSlotIdx   = emitIdxQ;
  assign cycSlotIdn   = emitIdnQ;
endmodule
`default_nettype wire

// file: bench/scs_scheduler_chk.sv
// Port checker for the service channel scheduler.
// Assumes it is bound onto scs_scheduler; one clock domain.
`timescale 1ns/100ps
`default_nettype none
module scs_scheduler_chk (
  input wire logic               clk,
  input wire logic               rst,
  input wire logic               cycleTick,
  input wire logic         [2:0] ringPhase,
  input wire logic               cyclicRun,
  input wire logic               ctlReqValid,
  input wire logic               ctlReqReady,
  input wire logic               ctlQueueFull,
  input wire logic               ctlReqRejected,
  input wire logic               diagReqReady,
  input wire logic               svcBusy,
  input wire logic        [15:0] mdtSvcWord,
  input wire logic               wrDataReady,
  input wire logic         [3:0] telLength,
  input wire logic               cfgWrEn,
  input wire scs_pkg::scs_elem_t cfgElem,
  input wire logic               cfgRefused,
  input wire logic         [3:0] cycCount,
  input wire logic               cycSlotValid,
  input wire logic         [2:0] cycSlotIdx
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);

  a_tel_len: assert property (telLength == cycCount + 4'h1)
    else $error("telegram length off");
  a_full_flag: assert property (ctlQueueFull == !ctlReqReady)
    else $error("queue full flag off");
  a_full_reject: assert property (ctlReqValid && !ctlReqReady
    |=> ctlReqRejected) else $error("no reject pulse");
  a_phase_step: assert property (ringPhase != $past(ringPhase)
    |-> ringPhase == $past(ringPhase) + 3'h1) else $error("phase skip");
  a_svc_gate: assert property (svcBusy
    |-> ringPhase >= scs_pkg::PHASE_SVC_MIN) else $error("early service");
  a_diag_idle: assert property (diagReqReady |-> !svcBusy)
    else $error("diag ready while busy");
  a_word_hold: assert property (!cycleTick |=> $stable(mdtSvcWord))
    else $error("service word moved off tick");
  a_wr_tick: assert property (wrDataReady |-> cycleTick)
    else $error("write word off tick");
  a_cyc_gate: assert property (cycSlotValid |-> cyclicRun)
    else $error("cyclic word before run");
  a_cyc_start: assert property (cycleTick && cyclicRun
    && cycCount != 4'h0 |=> cycSlotValid && cycSlotIdx == 3'h0)
    else $error("cyclic stream missing");
  a_cfg_lock: assert property (cfgWrEn && cyclicRun |=> cfgRefused)
    else $error("config not locked");
  a_cfg_elem: assert property (cfgWrEn
    && cfgElem != scs_pkg::ELEM_OPDATA |=> cfgRefused)
    else $error("non operation element mapped");
endmodule

bind scs_scheduler scs_scheduler_chk chk (
  .clk(clk), .rst(rst), .cycleTick(cycleTick), .ringPhase(ringPhase),
  .cyclicRun(cyclicRun), .ctlReqValid(ctlReqValid),
  .ctlReqReady(ctlReqReady), .ctlQueueFull(ctlQueueFull),
  .ctlReqRejected(ctlReqRejected), .diagReqReady(diagReqReady),
  .svcBusy(svcBusy), .mdtSvcWord(mdtSvcWord), .wrDataReady(wrDataReady),
  .telLength(telLength), .cfgWrEn(cfgWrEn), .cfgElem(cfgElem),
  .cfgRefused(cfgRefused), .cycCount(cycCount),
  .cycSlotValid(cycSlotValid), .cycSlotIdx(cycSlotIdx)
);
`default_nettype wire

// file: bench/scs_drive_model.sv
// Drive slave model: answers in its own telegram word on every tick.
// Assumes the scheduler samples the word at the tick edge.
`timescale 1ns/100ps
`default_nettype none
module scs_drive_model (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        cycleTick,
  output logic      [15:0] atSvcWord
);
  // Word changes every update so a stale sample is caught
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      atSvcWord <= 16'hd000;
    end else if (cycleTick) begin
      atSvcWord <= atSvcWord + 16'h0001;
    end
  end
endmodule
`default_nettype wire

// file: bench/scs_scheduler_tb.sv
// Self-checking bench for the service channel scheduler.
// Assumes an update tick every 8 clocks, made by the bench.
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, ex, gt) begin n_tests++; if ((gt) !== (ex)) begin \
  num_errors++; $display("wrong value %s exp %h got %h", nm, ex, gt); end end
module scs_scheduler_tb;
  logic clk, rst, cycleTick, phaseAdvReq, ctlReqValid, diagReqValid;
  logic wrDataValid, rspReady, cfgWrEn, ctlReqReady, ctlQueueFull;
  logic ctlReqRejected, diagReqReady, wrDataReady, rspValid, svcBusy;
  logic svcDone, svcDoneSrc, cyclicRun, cfgRefused, cycSlotValid;
  logic [2:0] ringPhase, cfgSlot, cycSlotIdx;
  logic [3:0] telLength, cycCount;
  logic [15:0] wrData, mdtSvcWord, atSvcWord, cfgIdn, cycSlotIdn, w0;
  scs_pkg::scs_req_t ctlReq, diagReq;
  scs_pkg::scs_rsp_t rsp;
  scs_pkg::scs_elem_t cfgElem;
  int num_errors, n_tests, cyc;
  logic doneQ[$];
  scs_pkg::scs_rsp_t rspQ[$];

  scs_scheduler dut (.clk, .rst, .cycleTick, .phaseAdvReq, .ringPhase,
    .cyclicRun, .ctlReqValid, .ctlReqReady, .ctlReq, .ctlQueueFull,
    .ctlReqRejected, .diagReqValid, .diagReqReady, .diagReq, .wrDataValid,
    .wrDataReady, .wrData, .rspValid, .rspReady, .rsp, .svcBusy, .svcDone,
    .svcDoneSrc, .mdtSvcWord, .atSvcWord, .telLength, .cfgWrEn, .cfgSlot,
    .cfgIdn, .cfgElem, .cfgRefused, .cycCount, .cycSlotValid, .cycSlotIdx,
    .cycSlotIdn);
  scs_drive_model drv (.clk, .rst, .cycleTick, .atSvcWord);

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  always @(posedge clk) begin
    cyc++;
    if (svcDone === 1'b1) doneQ.push_back(svcDoneSrc);
    if (rspValid === 1'b1 && rspReady === 1'b1) rspQ.push_back(rsp);
    if (cyc > 5000) begin
      num_errors++;
      end_of_test();
    end
    #1 cycleTick <= (cyc % 8 == 0);
  end

  task automatic end_of_test;
    $display("checks %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  task automatic tk;
    do @(posedge clk); while (cycleTick !== 1'b1);
    #1;
  endtask

  task automatic clk1;
    @(posedge clk);
    #1;
  endtask

  task automatic adv(input logic [2:0] ph);
    // One-clock pulse; the sequencer holds it until the tick
    phaseAdvReq = 1'b1;
    clk1();
    phaseAdvReq = 1'b0;
    tk();
    `CHK("phase", ph, ringPhase)
  endtask

  // Queue fills while service is still gated off
  task automatic t_fill;
    for (int i = 0; i < 17; i++) begin
      ctlReq = '{1'b0, scs_pkg::ELEM_OPDATA, 8'h05, 16'h0200 + 16'(i), 8'h00};
      ctlReqValid = 1'b1;
      clk1();
    end
    ctlReqValid = 1'b0;
    `CHK("full", 1'b1, ctlQueueFull)
    `CHK("reject", 1'b1, ctlReqRejected)
    tk();
    tk();
    `CHK("busy", 1'b0, svcBusy)
  endtask

  task automatic t_drain;
    diagReq = '{1'b0, scs_pkg::ELEM_NAME, 8'h06, 16'h0300, 8'h00};
    diagReqValid = 1'b1;
    for (int i = 0; i < 1200 && doneQ.size() < 17; i++) begin
      @(posedge clk);
      if (diagReqValid && diagReqReady === 1'b1) #1 diagReqValid = 1'b0;
    end
    `CHK("dones", 17, doneQ.size())
    for (int i = 0; i < 17; i++) `CHK("src", i == 16, doneQ[i])
  endtask

  task automatic t_write;
    scs_pkg::scs_elem_t el[6] = '{scs_pkg::ELEM_NAME, scs_pkg::ELEM_ATTR,
      scs_pkg::ELEM_UNITS, scs_pkg::ELEM_MIN, scs_pkg::ELEM_MAX,
      scs_pkg::ELEM_OPDATA};
    wrData = 16'h5a3c;
    wrDataValid = 1'b1;
    tk();
    for (int i = 0; i < 6; i++) begin
      ctlReq = '{1'b1, el[i], 8'h05, 16'h0100 + 16'(i), 8'h01};
      ctlReqValid = 1'b1;
      clk1();
    end
    ctlReqValid = 1'b0;
    for (int i = 0; i < 6; i++) begin
      tk();
      `CHK("hdr", {1'b1, el[i], 4'h0, 8'h05}, mdtSvcWord)
      tk();
      `CHK("idn", 16'h0100 + 16'(i), mdtSvcWord)
      tk();
      `CHK("data", 16'h5a3c, mdtSvcWord)
    end
    wrDataValid = 1'b0;
  endtask

  // Answer buffer fills and stalls the read, then drains
  task automatic t_read;
    rspReady = 1'b0;
    rspQ.delete();
    tk();
    ctlReq = '{1'b0, scs_pkg::ELEM_OPDATA, 8'h05, 16'h0400, 8'h0a};
    ctlReqValid = 1'b1;
    clk1();
    ctlReqValid = 1'b0;
    tk();
    tk();
    w0 = atSvcWord;
    repeat (12) tk();
    `CHK("stall", 1'b1, svcBusy)
    `CHK("held", 1'b1, rspValid)
    rspReady = 1'b1;
    repeat (6) tk();
    `CHK("words", 10, rspQ.size())
    for (int i = 0; i < 8; i++) `CHK("word", w0 + 16'(i), rspQ[i].word)
    `CHK("last", 1'b1, rspQ[9].last)
  endtask

  task automatic cfg(input scs_pkg::scs_elem_t e);
    // Idle edge first so back-to-back calls never re-raise the strobe at once
    clk1();
    cfgSlot = 3'h2;
    cfgIdn = 16'h0033;
    cfgElem = e;
    cfgWrEn = 1'b1;
    clk1();
    cfgWrEn = 1'b0;
  endtask

  task automatic t_cyc;
    cfg(scs_pkg::ELEM_NAME);
    `CHK("refuse", 1'b1, cfgRefused)
    cfg(scs_pkg::ELEM_OPDATA);
    `CHK("count", 4'h3, cycCount)
    `CHK("length", 4'h4, telLength)
    tk();
    clk1();
    `CHK("quiet", 1'b0, cycSlotValid)
    adv(3'h4);
    adv(3'h4);
    `CHK("run", 1'b1, cyclicRun)
    repeat (2) begin
      tk();
      for (int i = 0; i < 4 && cycSlotValid !== 1'b1; i++) clk1();
      for (int i = 0; i < 3; i++) begin
        `CHK("slot", 3'(i), cycSlotIdx)
        if (i == 2) `CHK("slot idn", 16'h0033, cycSlotIdn)
        clk1();
      end
      `CHK("slot end", 1'b0, cycSlotValid)
    end
    cfg(scs_pkg::ELEM_OPDATA);
    `CHK("locked", 1'b1, cfgRefused)
  endtask

  initial begin
    {phaseAdvReq, ctlReqValid, diagReqValid} = 3'h0;
    {wrDataValid, cfgWrEn} = 2'h0;
    rspReady = 1'b1;
    rst = 1'b1;
    {ctlReq, diagReq} = '0;
    {wrData, cfgIdn, cfgSlot} = '0;
    cfgElem = scs_pkg::ELEM_OPDATA;
    repeat (4) @(posedge clk);
    #1 rst = 1'b0;
    `CHK("length", 4'h1, telLength)
    t_fill();
    adv(3'h1);
    adv(3'h2);
    adv(3'h3);
    t_drain();
    t_write();
    t_read();
    t_cyc();
    end_of_test();
  end
endmodule
`default_nettype wire
